// >>> pkg/flash_frame_pkg.sv
package flash_frame_pkg;

  localparam int BYTE_BITS = 8;
  typedef logic [BYTE_BITS-1:0] byte_type;
  typedef logic [2:0] cnt3_type;

  // bit and byte counting within a frame
  localparam cnt3_type BIT_FIRST = 3'h0;
  localparam cnt3_type BIT_STEP = 3'h1;
  localparam cnt3_type BIT_LAST = 3'h7;
  localparam cnt3_type BYTE_CNT_MAX = 3'h7;

  // bytes in front of the first output byte
  localparam cnt3_type HDR_CMD = 3'h1;
  localparam cnt3_type HDR_ADDR = 3'h4;
  localparam cnt3_type HDR_ADDR_DUMMY = 3'h5;

  localparam byte_type OP_WRITE_ENABLE = 8'h06;
  localparam byte_type OP_WRITE_DISABLE = 8'h04;
  localparam byte_type OP_READ_ID = 8'h9f;
  localparam byte_type OP_READ_STATUS = 8'h05;
  localparam byte_type OP_WRITE_STATUS = 8'h01;
  localparam byte_type OP_READ_DATA = 8'h03;
  localparam byte_type OP_FAST_READ = 8'h0b;
  localparam byte_type OP_DUAL_OUT_READ = 8'h3b;
  localparam byte_type OP_DUAL_IO_READ = 8'hbb;
  localparam byte_type OP_QUAD_IO_READ = 8'heb;
  localparam byte_type OP_QUAD_PROGRAM = 8'h38;
  localparam byte_type OP_SECTOR_ERASE = 8'h20;
  localparam byte_type OP_BLOCK_ERASE = 8'hd8;
  localparam byte_type OP_CHIP_ERASE = 8'h60;
  localparam byte_type OP_CHIP_ERASE_ALT = 8'hc7;
  localparam byte_type OP_PAGE_PROGRAM = 8'h02;
  localparam byte_type OP_DEEP_POWER_DOWN = 8'hb9;
  localparam byte_type OP_RELEASE_POWER_DOWN = 8'hab;

  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_WEL_BIT = 1;
  localparam int STATUS_BITS = 2;

  localparam int SYNC_CS = 0;
  localparam int SYNC_RX = 1;
  localparam int SYNC_PART = 2;
  localparam int SYNC_ACK = 3;
  localparam int SYNC_BITS = 4;
  localparam logic [SYNC_BITS-1:0] SYNC_RESET = 4'h1;

  typedef enum logic [2:0] {
    ST_OPCODE = 3'b001,
    ST_ACTIVE = 3'b010,
    ST_STANDBY = 3'b100
  } link_state_type;

  typedef struct packed {
    logic valid;
    logic is_read;
    logic from_status;
    logic is_array;
    logic is_write;
    logic starts_busy;
    logic sets_wel;
    logic clears_wel;
    cnt3_type hdr_bytes;
  } op_info_type;

  typedef struct packed {
    byte_type opcode;
    logic executed;
    logic rej_partial;
    logic rej_busy;
    logic rej_no_wel;
    logic rej_unknown;
  } cmd_type;

  function automatic op_info_type read_op(input logic stat, input logic arr,
                                          input cnt3_type hdr);
    read_op = '{valid: 1'h1, is_read: 1'h1, from_status: stat, is_array: arr,
                hdr_bytes: hdr, default: '0};
  endfunction

  function automatic op_info_type write_op(input logic bsy, input logic set,
                                           input logic clr);
    write_op = '{valid: 1'h1, is_write: 1'h1, starts_busy: bsy, sets_wel: set,
                 clears_wel: clr, default: '0};
  endfunction

  function automatic op_info_type decode_op(input byte_type op);
    case (op)
      OP_READ_STATUS: decode_op = read_op(1'h1, 1'h0, HDR_CMD);
      OP_READ_ID: decode_op = read_op(1'h0, 1'h0, HDR_CMD);
      OP_RELEASE_POWER_DOWN: decode_op = read_op(1'h0, 1'h0, HDR_ADDR);
      OP_READ_DATA: decode_op = read_op(1'h0, 1'h1, HDR_ADDR);
      OP_FAST_READ, OP_DUAL_OUT_READ, OP_DUAL_IO_READ, OP_QUAD_IO_READ:
        decode_op = read_op(1'h0, 1'h1, HDR_ADDR_DUMMY);
      OP_WRITE_ENABLE: decode_op = write_op(1'h0, 1'h1, 1'h0);
      OP_WRITE_DISABLE: decode_op = write_op(1'h0, 1'h0, 1'h1);
      OP_WRITE_STATUS, OP_PAGE_PROGRAM, OP_QUAD_PROGRAM, OP_SECTOR_ERASE,
      OP_BLOCK_ERASE, OP_CHIP_ERASE, OP_CHIP_ERASE_ALT:
        decode_op = write_op(1'h1, 1'h0, 1'h0);
      OP_DEEP_POWER_DOWN: decode_op = write_op(1'h0, 1'h0, 1'h0);
      default: decode_op = '0;
    endcase
  endfunction

endpackage

// >>> design/flash_frame.sv
`timescale 1ns/1ps

// Summary of operation
// - unknown opcode: standby until chip select rises
// - standby keeps serial output released
// - valid opcode: active until chip select rises, except an array read while busy, which goes to standby
// - input bits sampled on rising clock edges
// - output bits change on falling clock edges
// - works with clock mode 0 and 3
// - read commands follow opcode with data out
// - reads may stop after any output bit
// - write commands need byte-aligned chip select rise
// - array access ignored while write busy
module flash_frame #(
  parameter int BUSY_CYCLES = 1000,
  parameter int FIFO_WIDTH = 8,
  parameter int FIFO_DEPTH = 2
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic LINK_SCLK,
  input wire logic CS_N,
  input wire logic SI,
  output logic SO,
  output logic SO_OE,
  input wire logic [FIFO_WIDTH-1:0] TX_DATA,
  input wire logic TX_VALID,
  output logic TX_READY,
  output flash_frame_pkg::byte_type RX_BYTE,
  output logic RX_VALID,
  output flash_frame_pkg::cmd_type CMD,
  output logic CMD_VALID,
  output logic BUSY,
  output logic WEL
);

  localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
  localparam int CW = $clog2(FIFO_DEPTH + 1);
  localparam int BW = $clog2(BUSY_CYCLES + 1);
  localparam int HB = flash_frame_pkg::BYTE_BITS - 2;

  // a value is taken once the second and third stage agree
  function automatic logic [flash_frame_pkg::SYNC_BITS-1:0] settle(
    input logic [flash_frame_pkg::SYNC_BITS-1:0] mid,
    input logic [flash_frame_pkg::SYNC_BITS-1:0] last,
    input logic [flash_frame_pkg::SYNC_BITS-1:0] held
  );
    settle = (~(mid ^ last) & last) | ((mid ^ last) & held);
  endfunction

  // ---------------- link domain ----------------
  logic fresh;
  flash_frame_pkg::cnt3_type bit_cnt;
  flash_frame_pkg::cnt3_type byte_cnt;
  flash_frame_pkg::byte_type shift_in;
  flash_frame_pkg::byte_type rx_hold;
  flash_frame_pkg::byte_type out_byte;
  logic rx_tgl;
  logic partial;
  logic data_ack_tgl;
  logic out_go;
  flash_frame_pkg::link_state_type link_state;
  flash_frame_pkg::op_info_type link_info;
  logic [flash_frame_pkg::STATUS_BITS-1:0] stat_src;
  logic [flash_frame_pkg::STATUS_BITS-1:0] stat_ff1;
  logic [flash_frame_pkg::STATUS_BITS-1:0] stat_ff2;
  logic [flash_frame_pkg::STATUS_BITS-1:0] stat_ff3;
  logic [flash_frame_pkg::STATUS_BITS-1:0] status_link;

  // ---------------- system domain ----------------
  logic [flash_frame_pkg::SYNC_BITS-1:0] sync_in;
  logic [flash_frame_pkg::SYNC_BITS-1:0] sync_ff1;
  logic [flash_frame_pkg::SYNC_BITS-1:0] sync_ff2;
  logic [flash_frame_pkg::SYNC_BITS-1:0] sync_ff3;
  logic [flash_frame_pkg::SYNC_BITS-1:0] stable;
  logic [flash_frame_pkg::SYNC_BITS-1:0] stable_q;
  logic cs_rise_q;
  flash_frame_pkg::cnt3_type sys_bytes;
  flash_frame_pkg::byte_type sys_opcode;
  logic [BW-1:0] busy_cnt;
  logic [FIFO_WIDTH-1:0] fifo_mem [FIFO_DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [CW-1:0] fifo_count;
  logic [FIFO_WIDTH-1:0] data_word;
  logic data_full;

  // chip select high ends every frame at once, clock or no clock
  wire rst_frame = RST | CS_N;

  // bit position counted from the first rising edge
  wire flash_frame_pkg::cnt3_type pos = fresh ? flash_frame_pkg::BIT_FIRST : bit_cnt;
  wire byte_done = (pos == flash_frame_pkg::BIT_LAST);
  wire flash_frame_pkg::cnt3_type next_bit_cnt = pos + flash_frame_pkg::BIT_STEP;

  // serial input shifted in on rising edges
  wire flash_frame_pkg::byte_type next_shift = {shift_in[HB:0] & {(HB+1){!fresh}}, SI};

  wire flash_frame_pkg::cnt3_type bytes_before = fresh ? '0 : byte_cnt;
  wire bytes_sat = (bytes_before == flash_frame_pkg::BYTE_CNT_MAX);
  wire flash_frame_pkg::cnt3_type bytes_after =
    bytes_sat ? bytes_before : bytes_before + flash_frame_pkg::BIT_STEP;
  wire is_first = (bytes_before == '0);

  wire flash_frame_pkg::op_info_type cur_info =
    is_first ? flash_frame_pkg::decode_op(next_shift) : link_info;

  // array reads refused while a write runs
  wire link_busy = status_link[flash_frame_pkg::STATUS_BUSY_BIT];
  wire refuse = !cur_info.valid || (cur_info.is_array && link_busy);

  // unknown opcode parks the link in standby
  wire flash_frame_pkg::link_state_type next_state =
    refuse ? flash_frame_pkg::ST_STANDBY : flash_frame_pkg::ST_ACTIVE;
  wire flash_frame_pkg::link_state_type eff_state = is_first ? next_state : link_state;

  // data out follows the opcode and header bytes
  wire load_out = byte_done && (eff_state == flash_frame_pkg::ST_ACTIVE) &&
                  cur_info.is_read && (bytes_after >= cur_info.hdr_bytes);

  // status byte always available for polling
  wire flash_frame_pkg::byte_type status_byte = flash_frame_pkg::byte_type'(status_link);
  wire flash_frame_pkg::byte_type next_out =
    cur_info.from_status ? status_byte : data_word[flash_frame_pkg::BYTE_BITS-1:0];

  // set on every frame start; the first rising edge clears it
  always_ff @(posedge LINK_SCLK or posedge rst_frame) begin
    if (rst_frame) begin
      fresh <= 1'h1;
    end else begin
      fresh <= 1'h0;
    end
  end

  // state held until chip select rises
  always_ff @(posedge LINK_SCLK or posedge rst_frame) begin
    if (rst_frame) begin
      link_state <= flash_frame_pkg::ST_OPCODE;
      out_go <= 1'h0;
    end else begin
      if (byte_done && is_first) begin
        link_state <= next_state;
      end
      if (byte_done) begin
        out_go <= load_out;
      end
    end
  end

  // these survive chip select so the system side can judge the frame end
  always_ff @(posedge LINK_SCLK or posedge RST) begin
    if (RST) begin
      bit_cnt <= '0;
      byte_cnt <= '0;
      shift_in <= '0;
      partial <= 1'h0;
    end else begin
      bit_cnt <= next_bit_cnt;
      byte_cnt <= byte_done ? bytes_after : bytes_before;
      shift_in <= next_shift;
      // clear only on an eighth edge
      partial <= !byte_done;
    end
  end

  always_ff @(posedge LINK_SCLK or posedge RST) begin
    if (RST) begin
      rx_hold <= '0;
      rx_tgl <= 1'h0;
      link_info <= '0;
    end else if (byte_done) begin
      rx_hold <= next_shift;
      rx_tgl <= ~rx_tgl;
      if (is_first) begin
        link_info <= cur_info;
      end
    end
  end

  always_ff @(posedge LINK_SCLK or posedge RST) begin
    if (RST) begin
      out_byte <= '0;
      data_ack_tgl <= 1'h0;
    end else if (load_out) begin
      out_byte <= next_out;
      if (!cur_info.from_status) begin
        data_ack_tgl <= ~data_ack_tgl;
      end
    end
  end

  // output changes on falling edges only
  // in mode 3 the first falling edge finds out_go low
  // chip select rise releases the pin mid-byte
  // standby never sets out_go, so the pin stays released
  always_ff @(negedge LINK_SCLK or posedge rst_frame) begin
    if (rst_frame) begin
      SO <= 1'h0;
      SO_OE <= 1'h0;
    end else begin
      SO <= out_go ? out_byte[~bit_cnt] : 1'h0;
      SO_OE <= out_go;
    end
  end

  assign stat_src[flash_frame_pkg::STATUS_BUSY_BIT] = BUSY;
  assign stat_src[flash_frame_pkg::STATUS_WEL_BIT] = WEL;

  // link clock runs only in frames; eight edges cover three stages
  always_ff @(posedge LINK_SCLK or posedge RST) begin
    if (RST) begin
      stat_ff1 <= '0;
      stat_ff2 <= '0;
      stat_ff3 <= '0;
      status_link <= '0;
    end else begin
      stat_ff1 <= stat_src;
      stat_ff2 <= stat_ff1;
      stat_ff3 <= stat_ff2;
      status_link <= (~(stat_ff2 ^ stat_ff3) & stat_ff3) |
                     ((stat_ff2 ^ stat_ff3) & status_link);
    end
  end

  // ---------------- crossing into the system domain ----------------
  assign sync_in[flash_frame_pkg::SYNC_CS] = CS_N;
  assign sync_in[flash_frame_pkg::SYNC_RX] = rx_tgl;
  assign sync_in[flash_frame_pkg::SYNC_PART] = partial;
  assign sync_in[flash_frame_pkg::SYNC_ACK] = data_ack_tgl;

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      sync_ff1 <= flash_frame_pkg::SYNC_RESET;
      sync_ff2 <= flash_frame_pkg::SYNC_RESET;
      sync_ff3 <= flash_frame_pkg::SYNC_RESET;
      stable <= flash_frame_pkg::SYNC_RESET;
      stable_q <= flash_frame_pkg::SYNC_RESET;
    end else begin
      sync_ff1 <= sync_in;
      sync_ff2 <= sync_ff1;
      sync_ff3 <= sync_ff2;
      stable <= settle(sync_ff2, sync_ff3, stable);
      stable_q <= stable;
    end
  end

  wire [flash_frame_pkg::SYNC_BITS-1:0] changed = stable ^ stable_q;
  wire cs_rise = changed[flash_frame_pkg::SYNC_CS] && stable[flash_frame_pkg::SYNC_CS];
  // byte count restarts at frame start, so a last byte seen with the rise still counts
  wire cs_fall = changed[flash_frame_pkg::SYNC_CS] && !stable[flash_frame_pkg::SYNC_CS];
  // rx_hold stays put for eight link clocks after its toggle
  wire rx_event = changed[flash_frame_pkg::SYNC_RX];
  wire ack_event = changed[flash_frame_pkg::SYNC_ACK];

  // ---------------- command execution at frame end ----------------
  wire flash_frame_pkg::op_info_type sys_info = flash_frame_pkg::decode_op(sys_opcode);
  // judged one cycle after the rise: the last byte may settle on the same edge
  wire frame_end = cs_rise_q && (sys_bytes != '0);

  // write-type commands need a whole number of bytes
  wire rej_partial = sys_info.is_write && stable[flash_frame_pkg::SYNC_PART];
  wire write_ok = sys_info.is_write && !rej_partial;

  // a running write is never disturbed
  wire rej_busy = BUSY && (sys_info.is_array || (write_ok && sys_info.starts_busy));
  wire rej_no_wel = write_ok && sys_info.starts_busy && !WEL && !BUSY;
  wire starts = write_ok && sys_info.starts_busy && WEL && !BUSY;
  wire simple_ok = write_ok && !sys_info.starts_busy;
  wire executed = sys_info.valid && !rej_busy && (sys_info.is_read || starts || simple_ok);

  wire flash_frame_pkg::cmd_type next_cmd = '{
    opcode: sys_opcode,
    executed: executed,
    rej_partial: rej_partial,
    rej_busy: rej_busy,
    rej_no_wel: rej_no_wel,
    rej_unknown: !sys_info.valid
  };

  wire sys_sat = (sys_bytes == flash_frame_pkg::BYTE_CNT_MAX);
  wire flash_frame_pkg::cnt3_type next_sys_bytes =
    sys_sat ? sys_bytes : sys_bytes + flash_frame_pkg::BIT_STEP;

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      sys_bytes <= '0;
      sys_opcode <= '0;
      RX_BYTE <= '0;
      RX_VALID <= 1'h0;
    end else begin
      RX_VALID <= rx_event;
      if (rx_event) begin
        RX_BYTE <= rx_hold;
      end
      if (rx_event && (sys_bytes == '0)) begin
        sys_opcode <= rx_hold;
      end
      if (cs_fall) begin
        sys_bytes <= '0;
      end else if (rx_event) begin
        sys_bytes <= next_sys_bytes;
      end
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      CMD <= '0;
      CMD_VALID <= 1'h0;
      cs_rise_q <= 1'h0;
    end else begin
      cs_rise_q <= cs_rise;
      CMD_VALID <= frame_end;
      if (frame_end) begin
        CMD <= next_cmd;
      end
    end
  end

  // latch changes only for accepted writes
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      WEL <= 1'h0;
    end else if (frame_end && simple_ok && sys_info.sets_wel) begin
      WEL <= 1'h1;
    end else if (frame_end && (starts || (simple_ok && sys_info.clears_wel))) begin
      WEL <= 1'h0;
    end
  end

  wire busy_done = (busy_cnt == '0);

  // stands in for the internal write or erase time
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      BUSY <= 1'h0;
      busy_cnt <= '0;
    end else if (frame_end && starts) begin
      BUSY <= 1'h1;
      busy_cnt <= BW'(BUSY_CYCLES - 1);
    end else if (BUSY) begin
      BUSY <= !busy_done;
      busy_cnt <= busy_done ? busy_cnt : busy_cnt - 1'h1;
    end
  end

  // ---------------- read data buffer ----------------
  wire fifo_push = TX_VALID && TX_READY;
  // drained one byte at a time as the link consumes data_word
  wire fifo_pop = (fifo_count != '0) && !data_full;
  wire [PW-1:0] wr_next = (wr_ptr == PW'(FIFO_DEPTH - 1)) ? '0 : wr_ptr + 1'h1;
  wire [PW-1:0] rd_next = (rd_ptr == PW'(FIFO_DEPTH - 1)) ? '0 : rd_ptr + 1'h1;
  wire [CW-1:0] next_count = fifo_count + CW'(fifo_push) - CW'(fifo_pop);

  always_ff @(posedge SYS_CLK) begin
    if (fifo_push) begin
      fifo_mem[wr_ptr] <= TX_DATA;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fifo_count <= '0;
      TX_READY <= 1'h1;
    end else begin
      wr_ptr <= fifo_push ? wr_next : wr_ptr;
      rd_ptr <= fifo_pop ? rd_next : rd_ptr;
      fifo_count <= next_count;
      TX_READY <= (next_count < CW'(FIFO_DEPTH));
    end
  end

  // data_word only changes while the link is not due to take it
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      data_word <= '0;
      data_full <= 1'h0;
    end else if (fifo_pop) begin
      data_word <= fifo_mem[rd_ptr];
      data_full <= 1'h1;
    end else if (ack_event) begin
      data_full <= 1'h0;
    end
  end

endmodule

// >>> test/flash_frame_assertions.sv
`timescale 1ns/1ps
module flash_frame_assertions #(
  parameter int BUSY_CYCLES = 1000
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic LINK_SCLK,
  input wire logic CS_N,
  input wire logic SI,
  input wire logic SO,
  input wire logic SO_OE,
  input wire logic RX_VALID,
  input wire flash_frame_pkg::cmd_type CMD,
  input wire logic CMD_VALID,
  input wire logic BUSY,
  input wire logic WEL
);
  logic [7:0] nbits;
  logic [7:0] shift;
  logic [7:0] op;
  logic so_at_rise;
  logic [15:0] busy_cnt;
  wire hdr_done = nbits >= 8'h08;
  wire short_rd = op == 8'h05 || op == 8'h9f;
  wire any_rd = short_rd || op == 8'h03 || op == 8'h0b || op == 8'h3b || op == 8'hbb
    || op == 8'heb || op == 8'hab;

  // chip select high clears the count, mirroring the block's own framing reset
  always_ff @(posedge LINK_SCLK or posedge CS_N) begin
    if (CS_N) begin
      nbits <= 8'h00;
    end else if (nbits != 8'hff) begin
      nbits <= nbits + 8'h01;
    end
  end

  always_ff @(posedge LINK_SCLK) begin
    shift <= {shift[6:0], SI};
    so_at_rise <= SO;
    if (nbits == 8'h07) begin
      op <= {shift[6:0], SI};
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      busy_cnt <= 16'h0000;
    end else begin
      busy_cnt <= BUSY ? busy_cnt + 16'h0001 : 16'h0000;
    end
  end

  quiet_header_a:
  assert property (@(posedge LINK_SCLK) disable iff (RST || CS_N) !hdr_done |-> !SO_OE)
    else $error("output enabled inside opcode byte");
  standby_quiet_a:
  assert property (@(posedge LINK_SCLK) disable iff (RST || CS_N)
    (hdr_done && !any_rd) |-> !SO_OE) else $error("output enabled after non-read opcode");
  status_out_a:
  assert property (@(posedge LINK_SCLK) disable iff (RST || CS_N)
    (hdr_done && short_rd) |-> SO_OE) else $error("short read gives no output");
  so_hold_a:
  assert property (@(negedge LINK_SCLK) disable iff (RST || CS_N)
    SO_OE |-> SO == so_at_rise) else $error("serial output moved on rising edge");
  cs_release_a:
  assert property (@(posedge SYS_CLK) disable iff (RST) CS_N |-> !SO_OE)
    else $error("output driven while deselected");
  wel_set_a:
  assert property (@(posedge SYS_CLK) disable iff (RST)
    (CMD_VALID && CMD.executed && CMD.opcode == 8'h06) |-> WEL)
    else $error("write enable did not set latch");
  reject_still_a:
  assert property (@(posedge SYS_CLK) disable iff (RST) (CMD_VALID && CMD.rej_partial)
    |-> !CMD.executed && WEL == $past(WEL) && !$rose(BUSY))
    else $error("rejected command had an effect");
  busy_len_a:
  assert property (@(posedge SYS_CLK) disable iff (RST)
    $fell(BUSY) |-> busy_cnt == BUSY_CYCLES) else $error("busy length wrong");
  rx_pulse_a:
  assert property (@(posedge SYS_CLK) disable iff (RST) RX_VALID |=> !RX_VALID)
    else $error("byte strobe longer than one cycle");

  cover property (@(posedge SYS_CLK) CMD_VALID && CMD.rej_partial);
  cover property (@(posedge SYS_CLK) CMD_VALID && CMD.rej_unknown);
  cover property (@(posedge SYS_CLK) $fell(BUSY));
endmodule

bind flash_frame flash_frame_assertions #(.BUSY_CYCLES(BUSY_CYCLES)) chk (
  .SYS_CLK(SYS_CLK), .RST(RST), .LINK_SCLK(LINK_SCLK), .CS_N(CS_N), .SI(SI), .SO(SO),
  .SO_OE(SO_OE), .RX_VALID(RX_VALID), .CMD(CMD), .CMD_VALID(CMD_VALID), .BUSY(BUSY),
  .WEL(WEL));

// >>> test/flash_host_model.sv
`timescale 1ns/1ps
module flash_host_model (
  output logic cs_n,
  output logic sclk,
  output logic si,
  input wire logic so
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si = 1'b0;
  end

  // odd start offset keeps link edges off the system clock edges
  task automatic frame(input logic m3, input logic [63:0] tx, input int n,
                       output logic [63:0] rx);
    sclk = m3;
    #1.3;
    cs_n = 1'b0;
    rx = '0;
    for (int i = 0; i < n; i++) begin
      if (sclk) begin
        #7.5;
        sclk = 1'b0;
      end
      si = tx[63-i];
      #7.5;
      sclk = 1'b1;
      rx[63-i] = so;
      if (!m3) begin
        #7.5;
        sclk = 1'b0;
      end
    end
    #7.5;
    cs_n = 1'b1;
    si = ~si;
    #100;
  endtask
endmodule

// >>> test/tb.sv
`timescale 1ns/1ps
`define CHK(what, exp, got) begin \
  checks_done++; \
  if ((got) !== (exp)) begin \
    fails++; \
    $display("[FAIL] %s expected %h seen %h", what, exp, got); \
  end \
end
module tb;
  localparam int BUSY_N = 200;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] tx_data = 8'h00;
  logic tx_valid = 1'b0;
  logic cs_n, sclk, si, so, so_oe, tx_ready, rx_valid, cmd_valid, busy, wel;
  flash_frame_pkg::byte_type rx_byte;
  flash_frame_pkg::cmd_type cmd;
  flash_frame_pkg::cmd_type last_cmd;
  wire so_line = so_oe ? so : 1'bz;
  int fails = 0;
  int checks_done = 0;
  int cycles = 0;
  logic oe_seen = 1'b0;
  logic cmd_seen = 1'b0;
  logic [63:0] rx;

  flash_frame #(.BUSY_CYCLES(BUSY_N)) DUT (.SYS_CLK(sys_clk), .RST(rst), .LINK_SCLK(sclk),
    .CS_N(cs_n), .SI(si), .SO(so), .SO_OE(so_oe), .TX_DATA(tx_data), .TX_VALID(tx_valid),
    .TX_READY(tx_ready), .RX_BYTE(rx_byte), .RX_VALID(rx_valid), .CMD(cmd),
    .CMD_VALID(cmd_valid), .BUSY(busy), .WEL(wel));
  flash_host_model host (.cs_n(cs_n), .sclk(sclk), .si(si), .so(so_line));

  initial begin
    forever #4 sys_clk = ~sys_clk;
  end

  // pulses are caught here because the host is still busy with its frame
  always @(posedge sys_clk) begin
    cycles++;
    if (so_oe === 1'b1) oe_seen <= 1'b1;
    if (cmd_valid === 1'b1) begin
      last_cmd <= cmd;
      cmd_seen <= 1'b1;
    end
    if (cycles == 6000) begin
      fails++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic go(input logic m3, input logic [63:0] tx, input int n);
    oe_seen = 1'b0;
    cmd_seen = 1'b0;
    host.frame(m3, tx, n, rx);
    repeat (2) @(posedge sys_clk);
  endtask

  task automatic push(input logic [7:0] b);
    logic ok;
    tx_data <= b;
    tx_valid <= 1'b1;
    ok = 1'b0;
    for (int i = 0; i < 20 && !ok; i++) begin
      @(negedge sys_clk);
      ok = (tx_ready === 1'b1);
      @(posedge sys_clk);
    end
  endtask

  task automatic t_status(input logic m3, input logic [7:0] exp);
    go(m3, {8'h05, 56'h0}, 24);
    `CHK("status bytes", {exp, exp}, rx[55:40])
  endtask

  task automatic t_reset();
    `CHK("reset outputs", 5'h10, {tx_ready, busy, wel, so_oe, cmd_valid})
    $display("test reset finished");
  endtask

  task automatic t_modes();
    t_status(1'b0, 8'h00);
    t_status(1'b1, 8'h00);
    go(1'b1, {8'h06, 56'h0}, 8);
    `CHK("enable cmd", {1'b1, 8'h06, 5'h10, 1'b1}, {cmd_seen, last_cmd, wel})
    t_status(1'b0, 8'h02);
    $display("test modes finished");
  endtask

  task automatic t_partial();
    go(1'b0, {8'h04, 56'h0}, 11);
    `CHK("partial cmd", {1'b1, 8'h04, 5'h08, 1'b1}, {cmd_seen, last_cmd, wel})
    $display("test partial finished");
  endtask

  task automatic t_unknown();
    go(1'b0, {8'hff, 56'h0}, 32);
    `CHK("unknown", 4'h6, {oe_seen, cmd_seen, last_cmd.rej_unknown, last_cmd.executed})
    t_status(1'b0, 8'h02);
    $display("test unknown finished");
  endtask

  task automatic t_read();
    push(8'ha5);
    push(8'h3c);
    push(8'h96);
    tx_valid <= 1'b0;
    repeat (3) @(posedge sys_clk);
    `CHK("buffer full", 1'b0, tx_ready)
    go(1'b0, {8'h03, 24'h123456, 32'h0}, 59);
    `CHK("read data", 24'ha53c96, rx[31:8])
    `CHK("cut short", 2'h1, {so_oe, tx_ready})
    $display("test read finished");
  endtask

  task automatic t_busy();
    go(1'b1, {8'h02, 24'h000100, 8'h5a, 24'h0}, 40);
    `CHK("program", {3'h7, 8'h5a}, {cmd_seen, last_cmd.executed, busy, rx_byte})
    push(8'hc3);
    tx_valid <= 1'b0;
    go(1'b0, {8'h03, 24'h000100, 32'h0}, 40);
    `CHK("ignored read", 2'h1, {oe_seen, busy})
    for (int i = 0; i < 400 && busy !== 1'b0; i++) @(posedge sys_clk);
    go(1'b0, {8'h05, 56'h0}, 16);
    `CHK("busy bit", 1'b0, rx[48])
    $display("test busy finished");
  endtask

  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    t_reset();
    t_modes();
    t_partial();
    t_unknown();
    t_read();
    t_busy();
    final_report();
  end
endmodule
